// ==== hw/glue_pkg.sv ====
// Package with constants and carrier types for the host I/O port glue.
package glue_pkg;

  // ************************************************************
  // Address windows
  // ************************************************************
  localparam logic [9:0] io_base_0      = 10'h300;
  localparam logic [9:0] io_base_1      = 10'h320;
  localparam logic [9:0] io_base_2      = 10'h340;
  localparam logic [9:0] io_base_3      = 10'h360;
  localparam int         window_lsb     = 5;
  localparam logic [4:0] reg_off_lo     = 5'h00;
  localparam logic [4:0] reg_off_hi     = 5'h0f;
  localparam logic [4:0] data_off_lo    = 5'h10;
  localparam logic [4:0] data_off_hi    = 5'h17;
  localparam logic [4:0] reset_off_lo   = 5'h18;
  localparam logic [4:0] reset_off_hi   = 5'h1f;
  localparam logic [5:0] rom_win_0      = 6'h32;
  localparam logic [5:0] rom_win_1      = 6'h33;
  localparam logic [5:0] rom_win_2      = 6'h34;
  localparam logic [5:0] rom_win_3      = 6'h35;

  // ************************************************************
  // Depths
  // ************************************************************
  localparam int         buf_depth      = 2;

  // One word moving between the port latch and the host side.
  typedef struct packed
  {
    logic [15:0] data;
  } port_word_type;

endpackage : glue_pkg

// ==== hw/isa_nic_io_port_glue.sv ====
// Host I/O bus to network controller glue: decode, waits and acks.
//
// Overview of operation
// (RQ1) ROM enable on matching memory read
// (RQ2) Controller select only for register range
// (RQ3) Host strobes become controller slave strobes
// (RQ4) Register read not ready holds host waiting
// (RQ5) Ready acknowledge releases host wait state
// (RQ6) Data buffer faces host on register read
// (RQ7) Register write completes on write strobe
// (RQ8) Cycle ends when host drops address
// (RQ9) Host writes five setup registers first
// (RQ10) Sixteen-bit values go as two bytes
// (RQ11) Bus request loops straight to grant
// (RQ12) Address strobe latches local address
// (RQ13) Remote read loads port latch
// (RQ14) Early data port read makes host wait
// (RQ15) Data port read with request acknowledges
// (RQ16) Data port write with request acknowledges
// (RQ17) Remote write moves latch into RAM
// (RQ18) Receive writes FIFO data into RAM
// (RQ19) Transmit reads RAM into controller FIFO
// (RQ20) Two jumpers choose I/O base
// (RQ21) ROM jumper makes base jumpers choose ROM
// (RQ22) Interrupt goes to one of four lines
// (RQ23) Window relocatable to four bases
// (RQ24) Window split registers, data, reset port; reset offsets decode as data here
// (RQ25) Ready pin released unless holding wait
// (RQ26) Register and data decodes never overlap
`timescale 1ns/1ps
`default_nettype none
module isa_nic_io_port_glue
(
  input  wire logic        clk,               // 40 MHz clock.
  input  wire logic        rst_n,             // Synchronous reset.
  // Host side.
  input  wire logic [19:0] sys_addr,          // Host address.
  input  wire logic        host_io_read_n,    // Host I/O read strobe.
  input  wire logic        host_io_write_n,   // Host I/O write strobe.
  input  wire logic        sys_mem_read_cmd_n,// Host memory read command.
  input  wire logic        sys_aen,           // Host DMA owns the bus.
  input  wire logic [15:0] host_data_in,      // Host data bus in.
  output logic      [15:0] host_data_out,     // Host data bus out.
  output logic             host_data_oe,      // Drive host data bus.
  output logic             iochrdy_out,       // Ready pin level.
  output logic             iochrdy_oe,        // Ready pin driven.
  output logic      [3:0]  irq_out,           // Lines 9,3,4,5.
  output logic             boot_rom_enable_n, // ROM and its buffer.
  // Configuration.
  input  wire logic        base_sel_hi,       // Base jumper high, on = 0.
  input  wire logic        base_sel_lo,       // Base jumper low, on = 0.
  input  wire logic        rom_addr_jumper,   // High: jumpers pick ROM.
  input  wire logic [1:0]  irq_base_jumper_block, // Interrupt line pick.
  // Controller side.
  output logic             nic_cs_n,          // Controller select.
  output logic      [3:0]  nic_reg_addr,      // Register address.
  output logic             slave_read_n,      // Slave read strobe.
  output logic             slave_write_n,     // Slave write strobe.
  input  wire logic        slave_ack_n,       // Slave acknowledge.
  output logic             reg_buf_to_host,   // Byte buffer toward host.
  output logic             reg_buf_oe,        // Byte buffer enabled.
  input  wire logic        local_bus_request, // Controller bus request.
  output logic             local_bus_grant,   // Grant to controller.
  input  wire logic        address_latch_strobe, // Local address strobe.
  input  wire logic [15:0] local_ad,          // Muxed address/data.
  output logic      [13:0] ram_addr,          // Latched RAM address.
  input  wire logic        mem_read_n,        // Local memory read.
  input  wire logic        mem_write_n,       // Local memory write.
  output logic             ram_oe_n,          // RAM output enable.
  output logic             ram_we_n,          // RAM write enable.
  input  wire logic        port_write_strobe, // Load read-side latch.
  input  wire logic        port_read_strobe,  // Drive write-side latch.
  input  wire logic        port_request,      // Port has data or room.
  output logic             port_read_ack,     // Port read ack.
  output logic             port_write_ack,    // Port write ack.
  output logic      [15:0] port_to_ram,       // Write-side latch data.
  output logic             port_to_ram_oe,    // Latch drives local bus.
  input  wire logic        nic_int            // Controller interrupt.
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Pins pass three flops; a level counts once stages two and three agree.
  localparam int n_sync = 2;
  logic [n_sync-1:0] raw;
  logic [n_sync-1:0] s1;
  logic [n_sync-1:0] s2;
  logic [n_sync-1:0] s3;
  logic [n_sync-1:0] pin;

  assign raw = {address_latch_strobe, port_write_strobe};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < n_sync; g++)
    begin : g_filt
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          pin[g] <= 1'b0;
        end
        else if (s2[g] == s3[g])
        begin
          pin[g] <= s3[g];
        end
      end
    end
  endgenerate

  logic ads_q;
  logic pwr_q;
  logic ads_prev;

  assign ads_q     = pin[1];
  assign pwr_q     = pin[0];

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic [9:0] base_of(input logic [1:0] sel);
    case (sel)
      2'b00:   base_of = glue_pkg::io_base_0;
      2'b01:   base_of = glue_pkg::io_base_1;
      2'b10:   base_of = glue_pkg::io_base_2;
      default: base_of = glue_pkg::io_base_3;
    endcase
  endfunction : base_of

  function automatic logic in_range(input logic [4:0] off,
                                    input logic [4:0] lo,
                                    input logic [4:0] hi);
    in_range = (off >= lo) && (off <= hi);
  endfunction : in_range

  logic [1:0] base_sel;
  logic       in_window;
  logic [4:0] offset;
  logic       reg_hit;
  logic       data_hit;

  assign base_sel  = {base_sel_hi, base_sel_lo}; // RQ20
  assign in_window = !sys_aen &&
    (sys_addr[9:glue_pkg::window_lsb] ==
     base_of(base_sel)[9:glue_pkg::window_lsb]); // RQ23
  assign offset    = sys_addr[4:0];
  assign reg_hit   = in_window &&
    in_range(offset, glue_pkg::reg_off_lo, glue_pkg::reg_off_hi); // RQ24
  // Reset-port offsets decode to the data path as well.
  assign data_hit  = in_window && !reg_hit &&
    in_range(offset, glue_pkg::data_off_lo, glue_pkg::reset_off_hi); // RQ26

  // ************************************************************
  // Register path
  // ************************************************************
  logic rd_strobe;
  logic wr_strobe;
  assign rd_strobe = !host_io_read_n;
  assign wr_strobe = !host_io_write_n;

  always_comb
  begin
    nic_cs_n        = !(reg_hit && (rd_strobe || wr_strobe)); // RQ2 RQ8
    nic_reg_addr    = sys_addr[3:0]; // RQ2
    slave_read_n    = !(reg_hit && rd_strobe); // RQ3
    slave_write_n   = !(reg_hit && wr_strobe); // RQ3 RQ7
    reg_buf_oe      = reg_hit && (rd_strobe || wr_strobe);
    reg_buf_to_host = reg_hit && rd_strobe; // RQ6
  end

  // ************************************************************
  // Ready line
  // ************************************************************
  logic wait_reg;
  logic wait_port;
  assign wait_reg  = reg_hit && rd_strobe && slave_ack_n; // RQ4 RQ5
  assign wait_port = data_hit && rd_strobe && !port_request; // RQ14

  always_comb
  begin
    iochrdy_out = 1'b0;
    iochrdy_oe  = wait_reg || wait_port; // RQ25
  end

  // ************************************************************
  // Data port acknowledges and host-side buffer
  // ************************************************************
  assign port_read_ack  = data_hit && rd_strobe && port_request; // RQ15
  assign port_write_ack = data_hit && wr_strobe && port_request; // RQ16

  // Read-side latch loads on the rising edge of the port write strobe.
  logic                    pwr_prev;
  logic                    load_pulse;
  glue_pkg::port_word_type rd_latch;
  glue_pkg::port_word_type ad_word;
  glue_pkg::port_word_type head;
  logic                    head_valid;
  logic                    buf_ready;
  logic                    pop;
  logic                    port_read_ack_prev;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwr_prev  <= 1'b0;
      port_read_ack_prev <= 1'b0;
      ads_prev  <= 1'b0;
    end
    else
    begin
      pwr_prev  <= pwr_q;
      port_read_ack_prev <= port_read_ack;
      ads_prev  <= ads_q;
    end
  end

  assign load_pulse = pwr_q && !pwr_prev; // RQ13

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_latch <= '0;
    end
    else if (load_pulse)
    begin
      rd_latch.data <= local_ad; // RQ13
    end
  end

  // A word leaves the buffer when the host read acknowledge ends.
  assign pop = port_read_ack_prev && !port_read_ack;
  // The buffer takes the bus word itself, as the latch loads on that edge.
  assign ad_word = '{data: local_ad};

  word_buffer i_word_buffer
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_word   (ad_word),
    .in_valid  (load_pulse),
    .in_ready  (buf_ready),
    .out_word  (head),
    .out_valid (head_valid),
    .out_ready (pop)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      host_data_out <= '0;
    end
    else
    begin
      host_data_out <= head_valid ? head.data : rd_latch.data; // RQ15
    end
  end

  assign host_data_oe = port_read_ack; // RQ15

  // Write-side latch captures host data while the write ack stands.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_to_ram <= '0;
    end
    else if (port_write_ack)
    begin
      port_to_ram <= host_data_in; // RQ16
    end
  end

  assign port_to_ram_oe = port_read_strobe; // RQ17

  // ************************************************************
  // Local bus
  // ************************************************************
  assign local_bus_grant = local_bus_request; // RQ11

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ram_addr <= '0;
    end
    else if (ads_q && !ads_prev)
    begin
      ram_addr <= local_ad[13:0]; // RQ12
    end
  end

  // RAM strobes follow the controller; receive, remote write and transmit.
  assign ram_we_n = mem_write_n; // RQ17 RQ18
  assign ram_oe_n = mem_read_n; // RQ13 RQ19

  // ************************************************************
  // Boot ROM and interrupt routing
  // ************************************************************
  function automatic logic [5:0] rom_win(input logic [1:0] sel);
    case (sel)
      2'b00:   rom_win = glue_pkg::rom_win_0;
      2'b01:   rom_win = glue_pkg::rom_win_1;
      2'b10:   rom_win = glue_pkg::rom_win_2;
      default: rom_win = glue_pkg::rom_win_3;
    endcase
  endfunction : rom_win

  assign boot_rom_enable_n = !(!sys_mem_read_cmd_n && rom_addr_jumper &&
    (sys_addr[19:14] == rom_win(base_sel))); // RQ1 RQ21

  always_comb
  begin
    irq_out = 4'h0;
    irq_out[irq_base_jumper_block] = nic_int; // RQ22
  end

  // ************************************************************
  // Unused buffer status
  // ************************************************************
  logic unused;
  assign unused = buf_ready;

endmodule : isa_nic_io_port_glue
`default_nettype wire

// ==== hw/word_buffer.sv ====
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module word_buffer
(
  input  wire logic                   clk,      // System clock.
  input  wire logic                   rst_n,    // Synchronous reset.
  input  wire glue_pkg::port_word_type in_word,  // Word in.
  input  wire logic                   in_valid, // Word in is valid.
  output logic                        in_ready, // Room for a word.
  output glue_pkg::port_word_type     out_word, // Oldest word, registered.
  output logic                        out_valid,// Oldest word present.
  input  wire logic                   out_ready // Drain side takes it.
);

  glue_pkg::port_word_type mem [glue_pkg::buf_depth];
  logic                    wr_ptr;
  logic                    rd_ptr;
  logic [1:0]              count;
  logic                    push;
  logic                    pop;

  assign in_ready  = (count != 2'(glue_pkg::buf_depth));
  assign out_valid = (count != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_word;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  // The head word is held in a flop so the host data pins see no glitch.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_word <= '0;
    end
    else if (pop && count == 2'h2)
    begin
      out_word <= mem[~rd_ptr];
    end
    else if (push && (count == 2'h0 || (pop && count == 2'h1)))
    begin
      out_word <= in_word;
    end
    else if (count != 2'h0)
    begin
      out_word <= mem[rd_ptr];
    end
  end

endmodule : word_buffer
`default_nettype wire

// ==== verification/glue_checker_assertions.sv ====
// Concurrent checks on the host I/O port glue.
`timescale 1ns/1ps
`default_nettype none
module glue_checker
(
  input wire logic        clk,               // Clock.
  input wire logic        rst_n,             // Reset.
  input wire logic [19:0] sys_addr,          // Host address.
  input wire logic        host_io_read_n,    // Host read.
  input wire logic        host_io_write_n,   // Host write.
  input wire logic        sys_aen,           // DMA owns bus.
  input wire logic        host_data_oe,      // Host bus drive.
  input wire logic        iochrdy_out,       // Ready level.
  input wire logic        iochrdy_oe,        // Ready driven.
  input wire logic        base_sel_hi,       // Base jumper.
  input wire logic        base_sel_lo,       // Base jumper.
  input wire logic        nic_cs_n,          // Select.
  input wire logic [3:0]  nic_reg_addr,      // Register address.
  input wire logic        slave_read_n,      // Slave read.
  input wire logic        slave_write_n,     // Slave write.
  input wire logic        slave_ack_n,       // Slave ack.
  input wire logic        reg_buf_to_host,   // Buffer direction.
  input wire logic        reg_buf_oe,        // Buffer enable.
  input wire logic        local_bus_request, // Bus request.
  input wire logic        local_bus_grant,   // Bus grant.
  input wire logic        port_request,      // Port ready.
  input wire logic        port_read_ack,     // Read ack.
  input wire logic        port_write_ack     // Write ack.
);
  // ************************************************************
  // Decode of the host cycle
  // ************************************************************
  logic [4:0] win_tag;
  logic       reg_hit;
  logic       dat_hit;
  logic       rd;
  logic       wr;
  assign win_tag = 5'h18 + {3'h0, base_sel_hi, base_sel_lo};
  assign reg_hit = !sys_aen && sys_addr[9:5] == win_tag && !sys_addr[4];
  assign dat_hit = !sys_aen && sys_addr[9:5] == win_tag && sys_addr[4];
  assign rd      = !host_io_read_n;
  assign wr      = !host_io_write_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cs_decode: assert property (nic_cs_n == !(reg_hit && (rd || wr)))
    else $error("select decode wrong");
  a_slave_strobes: assert property (!nic_cs_n |-> slave_read_n == !rd
    && slave_write_n == !wr && nic_reg_addr == sys_addr[3:0])
    else $error("slave strobes wrong");
  a_ready_wait: assert property (iochrdy_oe ==
    (rd && (reg_hit && slave_ack_n || dat_hit && !port_request)))
    else $error("wait state wrong");
  a_ready_low: assert property (iochrdy_oe |-> !iochrdy_out)
    else $error("ready driven high");
  a_ready_release: assert property ((reg_hit && rd && slave_ack_n)
    ##1 (reg_hit && rd && !slave_ack_n) |-> !iochrdy_oe)
    else $error("wait not released");
  a_buf_dir: assert property (!nic_cs_n |-> reg_buf_oe && reg_buf_to_host == rd)
    else $error("buffer direction wrong");
  a_grant_loop: assert property (local_bus_grant == local_bus_request)
    else $error("grant not looped");
  a_read_ack: assert property (port_read_ack == (dat_hit && rd && port_request)
    && host_data_oe == port_read_ack)
    else $error("read ack wrong");
  a_write_ack: assert property (port_write_ack == (dat_hit && wr && port_request))
    else $error("write ack wrong");
  a_paths_apart: assert property (nic_cs_n || !(port_read_ack || port_write_ack))
    else $error("both paths active");
endmodule : glue_checker

bind isa_nic_io_port_glue glue_checker i_glue_checker
(
  .clk, .rst_n, .sys_addr, .host_io_read_n, .host_io_write_n, .sys_aen,
  .host_data_oe, .iochrdy_out, .iochrdy_oe, .base_sel_hi, .base_sel_lo,
  .nic_cs_n, .nic_reg_addr, .slave_read_n, .slave_write_n, .slave_ack_n,
  .reg_buf_to_host, .reg_buf_oe, .local_bus_request, .local_bus_grant,
  .port_request, .port_read_ack, .port_write_ack
);
`default_nettype wire

// ==== verification/isa_nic_io_port_glue_tb.sv ====
// Self-checking testbench for the host I/O port glue.
`timescale 1ns/1ps
`default_nettype none
module isa_nic_io_port_glue_tb;
  // ************************************************************
  // Signals, instances and host cycles
  // ************************************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [19:0] sys_addr = 20'h00000;
  logic [15:0] host_data_in = 16'h0000;
  logic        host_io_read_n = 1'b1, host_io_write_n = 1'b1;
  logic        sys_mem_read_cmd_n = 1'b1, sys_aen = 1'b0, nic_int = 1'b0;
  logic        base_sel_hi = 1'b0, base_sel_lo = 1'b0, rom_addr_jumper = 1'b0;
  logic [1:0]  irq_base_jumper_block = 2'h1;
  logic [15:0] host_data_out, local_ad, port_to_ram, got;
  logic [13:0] ram_addr;
  logic [3:0]  irq_out, nic_reg_addr;
  logic        host_data_oe, iochrdy_out, iochrdy_oe, boot_rom_enable_n;
  logic        nic_cs_n, slave_read_n, slave_write_n, slave_ack_n, cs_low;
  logic        reg_buf_to_host, reg_buf_oe, local_bus_request, local_bus_grant;
  logic        address_latch_strobe, mem_read_n, mem_write_n, ram_oe_n;
  logic        ram_we_n, port_write_strobe, port_read_strobe, port_request;
  logic        port_read_ack, port_write_ack, port_to_ram_oe, ready;
  int          failures = 0, total_checks = 0, cycles = 0, waits;

  // The ready line has a pull-up, so a released pin reads high.
  assign ready = iochrdy_oe ? iochrdy_out : 1'b1;
  always #12.5 clk = ~clk;

  isa_nic_io_port_glue i_isa_nic_io_port_glue
  (
    .clk, .rst_n, .sys_addr, .host_io_read_n, .host_io_write_n,
    .sys_mem_read_cmd_n, .sys_aen, .host_data_in, .host_data_out,
    .host_data_oe, .iochrdy_out, .iochrdy_oe, .irq_out, .boot_rom_enable_n,
    .base_sel_hi, .base_sel_lo, .rom_addr_jumper, .irq_base_jumper_block,
    .nic_cs_n, .nic_reg_addr, .slave_read_n, .slave_write_n, .slave_ack_n,
    .reg_buf_to_host, .reg_buf_oe, .local_bus_request, .local_bus_grant,
    .address_latch_strobe, .local_ad, .ram_addr, .mem_read_n, .mem_write_n,
    .ram_oe_n, .ram_we_n, .port_write_strobe, .port_read_strobe,
    .port_request, .port_read_ack, .port_write_ack, .port_to_ram,
    .port_to_ram_oe, .nic_int
  );

  nic_model i_nic_model
  (
    .clk, .rst_n, .slave_read_n, .slave_write_n, .local_bus_grant, .ram_addr,
    .ram_oe_n, .ram_we_n, .port_to_ram_oe, .slave_ack_n, .local_bus_request,
    .address_latch_strobe, .local_ad, .mem_read_n, .mem_write_n,
    .port_write_strobe, .port_read_strobe, .port_request
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // The strobe stands until ready is sampled high; data is taken there.
  task automatic host_io(input logic [9:0] a, input logic rd,
                         input logic [15:0] d);
    repeat (2) @(posedge clk);
    #1 sys_addr = {10'h000, a};
    host_data_in = d;
    {host_io_read_n, host_io_write_n} = {!rd, rd};
    waits = 0;
    @(posedge clk);
    cs_low = !nic_cs_n;
    while (ready !== 1'b1 && waits < 200)
    begin
      waits++;
      @(posedge clk);
    end
    got = host_data_out;
    #1 {host_io_read_n, host_io_write_n} = 2'h3;
    sys_addr = ~sys_addr;
    host_data_in = ~d;
  endtask : host_io

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    for (int s = 0; s < 4; s++)
    begin
      {base_sel_hi, base_sel_lo} = 2'(s);
      i_nic_model.ack_wait = s;
      host_io(10'h305 + 10'(32 * s), 1'b1, 16'h0000);
      check(cs_low, 1);
      check(waits, s + 1);
      host_io(10'h30f + 10'(32 * s), 1'b0, 16'h00a5);
      check({cs_low, 8'(waits)}, 9'h100);
      host_io(10'h305 + 10'(32 * ((s + 1) % 4)), 1'b0, 16'h0011);
      check(cs_low, 0);
      host_io(10'h310 + 10'(32 * s), 1'b0, 16'h0022);
      check(cs_low, 0);
    end
    {base_sel_hi, base_sel_lo, sys_aen} = 3'h1;
    host_io(10'h305, 1'b0, 16'h0033);
    check(cs_low, 0);
    sys_aen = 1'b0;
    $display("test register decode done");
    for (int s = 0; s < 5; s++)
    begin
      @(posedge clk);
      #1 {base_sel_hi, base_sel_lo, irq_base_jumper_block} = {2'(s), 2'(s)};
      {nic_int, sys_mem_read_cmd_n, rom_addr_jumper} = {s < 4, 2'h1};
      sys_addr = {6'h32 + 6'(s), 14'h0100};
      @(negedge clk);
      check(boot_rom_enable_n, s > 3);
      check(irq_out, (s < 4) ? 4'h1 << s : 4'h0);
      @(posedge clk);
      #1 rom_addr_jumper = 1'b0;
      @(negedge clk);
      check(boot_rom_enable_n, 1);
    end
    {sys_mem_read_cmd_n, base_sel_hi, base_sel_lo} = 3'h4;
    $display("test rom and interrupt done");
    for (int k = 0; k < 5; k++)
    begin
      host_io(10'h30a - 10'(k), 1'b0, 16'h0001);
      check(cs_low, 1);
    end
    i_nic_model.local_cycle(14'h0040, 4'ha, 16'h1234);
    check(i_nic_model.seen, {14'h0040, 3'b010});
    i_nic_model.local_cycle(14'h0041, 4'ha, 16'h5678);
    i_nic_model.port_request = 1'b1;
    host_io(10'h310, 1'b1, 16'h0000);
    check({cs_low, 8'(waits), got}, {9'h000, 16'h1234});
    host_io(10'h316, 1'b1, 16'h0000);
    check(got, 16'h5678);
    i_nic_model.port_request = 1'b0;
    fork
      host_io(10'h312, 1'b1, 16'h0000);
      begin
        i_nic_model.local_cycle(14'h0042, 4'ha, 16'h9abc);
        repeat (2) @(posedge clk);
        #1 i_nic_model.port_request = 1'b1;
      end
    join
    check({waits > 10, got}, {1'b1, 16'h9abc});
    $display("test remote read done");
    host_io(10'h314, 1'b0, 16'hbeef);
    check(port_to_ram, 16'hbeef);
    i_nic_model.port_request = 1'b0;
    i_nic_model.local_cycle(14'h0100, 4'h5, 16'h0000);
    check({i_nic_model.seen, port_to_ram}, {14'h0100, 3'b101, 16'hbeef});
    i_nic_model.local_cycle(14'h0200, 4'h4, 16'h7777);
    check(i_nic_model.seen, {14'h0200, 3'b100});
    i_nic_model.local_cycle(14'h0300, 4'h8, 16'h0000);
    check(i_nic_model.seen, {14'h0300, 3'b010});
    $display("test remote write and local bus done");
    conclude();
  end
endmodule : isa_nic_io_port_glue_tb
`default_nettype wire

// ==== verification/nic_model.sv ====
// Behavioural model of the network controller beside the glue.
`timescale 1ns/1ps
`default_nettype none
module nic_model
(
  input  wire logic        clk,                  // Clock.
  input  wire logic        rst_n,                // Reset.
  input  wire logic        slave_read_n,         // Slave read.
  input  wire logic        slave_write_n,        // Slave write.
  input  wire logic        local_bus_grant,      // Grant.
  input  wire logic [13:0] ram_addr,             // RAM address.
  input  wire logic        ram_oe_n,             // RAM read.
  input  wire logic        ram_we_n,             // RAM write.
  input  wire logic        port_to_ram_oe,       // Latch drive.
  output logic             slave_ack_n,          // Slave ack.
  output logic             local_bus_request,    // Bus request.
  output logic             address_latch_strobe, // Address strobe.
  output logic      [15:0] local_ad,             // Address/data.
  output logic             mem_read_n,           // Memory read.
  output logic             mem_write_n,          // Memory write.
  output logic             port_write_strobe,    // Load port latch.
  output logic             port_read_strobe,     // Drive port latch.
  output logic             port_request          // Port ready.
);
  // ************************************************************
  // Slave answer and local bus cycles
  // ************************************************************
  int          ack_wait = 0;
  int          cnt;
  logic [16:0] seen;

  initial
  begin
    {slave_ack_n, mem_read_n, mem_write_n} = 3'h7;
    {local_bus_request, address_latch_strobe, port_request} = 3'h0;
    {port_write_strobe, port_read_strobe, local_ad} = 18'h00000;
  end

  // A read is held off for ack_wait cycles so the host wait path is used.
  always @(posedge clk)
  begin
    if (!rst_n || (slave_read_n && slave_write_n))
    begin
      cnt <= 0;
      slave_ack_n <= 1'b1;
    end
    else if (!slave_write_n || cnt >= ack_wait)
      slave_ack_n <= 1'b0;
    else
      cnt <= cnt + 1;
  end

  // Op bits: memory read, memory write, port write, port read.
  task automatic local_cycle(input logic [13:0] a, input logic [3:0] op,
                             input logic [15:0] w);
    @(posedge clk);
    #1 local_bus_request = 1'b1;
    @(posedge clk);
    #1 local_ad = {2'h0, a};
    address_latch_strobe = local_bus_grant;
    repeat (6) @(posedge clk);
    #1 address_latch_strobe = 1'b0;
    local_ad = w;
    {mem_read_n, mem_write_n} = ~op[3:2];
    {port_write_strobe, port_read_strobe} = op[1:0];
    repeat (5) @(posedge clk);
    seen = {ram_addr, ram_oe_n, ram_we_n, port_to_ram_oe};
    #1 {mem_read_n, mem_write_n} = 2'h3;
    {port_write_strobe, port_read_strobe, local_bus_request} = 3'h0;
    local_ad = ~w;
  endtask : local_cycle
endmodule : nic_model
`default_nettype wire
